// ===== verilog/cfg_space_defines.vh
// offsets, field positions, reset values for the configuration space
`ifndef CFG_SPACE_DEFINES_VH
`define CFG_SPACE_DEFINES_VH

`define OFF_IDENT        8'h00
`define OFF_CMDSTAT      8'h04
`define OFF_REVISION     8'h08
`define OFF_LATENCY      8'h0C
`define OFF_IOBASE       8'h10
`define OFF_MEMBASE      8'h14
`define OFF_SUBSYS       8'h2C
`define OFF_ROMBASE      8'h30
`define OFF_CAPABILITY_LIST_POINTER       8'h34
`define OFF_INTSEL       8'h3C
`define OFF_POWER_CAPABILITIES        8'h40
`define OFF_PMCTRL       8'h44

`define ID_DEVICE_MSB    31
`define ID_DEVICE_LSB    16
`define ID_VENDOR_MSB    15
`define ID_VENDOR_LSB    0

`define ST_PARITY_ERR    31
`define ST_SYSERR_SIG    30
`define ST_MABORT_RCV    29
`define ST_TABORT_RCV    28
`define ST_TABORT_SENT   27
`define ST_SELTIM_MSB    26
`define ST_SELTIM_LSB    25
`define ST_DATA_PARITY   24
`define ST_FASTB2B       23
`define ST_NEWCAP        20
`define SELTIM_MEDIUM    2'h1

`define CMD_WRITE_MASK   16'h0347
`define CMD_RESET        16'h0000
`define STAT_FIXED       16'h0290
`define STAT_W1C_MASK    16'hF900

`define IOBASE_MASK      32'hFFFFFF00
`define IOBASE_RESET     32'h00000001
`define MEMBASE_MASK     32'hFFFFF000
`define MEMBASE_RESET    32'h00000000
`define ROMBASE_MASK     32'hFFFF0001
`define ROMBASE_RESET    32'h00000000
`define INTSEL_MASK      32'h000000FF
`define INTSEL_RESET     32'h00000000
`define PMCTRL_MASK      32'h00000103
`define PMCTRL_W1C       32'h00008000
`define PMCTRL_PME_BIT   15
`define PMCTRL_RESET     32'h00000000

`endif

// ===== verilog/pci_config_space_header.v
// configuration register space of a network controller, served by type-0 config cycles
//
// How it works
// - the block presents a standard 256-byte PCI 2.2 configuration header so firmware can set it up in software.
// - a software reset request does not touch any configuration register.
// - the hardware reset returns every configuration register to its reset value.
// - writes to unused locations are dropped with no side effect and reads of them return zero.
// - offsets 18h to 28h, 38h and 48h to FFh always read as zero.
// - 00h, 08h, 0Ch, 2Ch, 34h, 40h are read-only and 04h, 10h, 14h, 30h, 3Ch, 44h are writable.
// - the identification register returns the device identifier high and the vendor identifier low, fixed.
// - writing a 1 to a status flag bit (31 to 27 or 24) of the command/status register clears it, a 0 leaves it.
// - the lower half of the command/status register holds writable command bits that steer the bus logic.
// - the select timing field always reads 01 and ignores writes.
// - status flags are set by bus events at bits 31, 30, 29, 28, 27 and 24.
`timescale 1ns/1ps
`include "cfg_space_defines.vh"

module pci_config_space_header #(
  parameter [15:0] DEVICE_IDENTIFIER = 16'h1234,  // arbitrary value
  parameter [15:0] VENDOR_IDENTIFIER = 16'hABCD,  // arbitrary value
  parameter [31:0] REVISION_VALUE    = 32'h02000000,
  parameter [31:0] LATENCY_VALUE     = 32'h00000000,
  parameter [31:0] SUBSYSTEM_VALUE   = 32'h00000000,  // arbitrary value
  parameter [7:0]  CAP_POINTER       = 8'h40,
  parameter [31:0] POWER_CAPABILITIES_VALUE       = 32'h00020001
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        softResetReq,
  input  wire        cfgRequest,
  input  wire        cfgWrite,
  input  wire        cfgTypeZero,
  input  wire        cfgSelect,
  input  wire [7:2]  cfgDwordAddr,
  input  wire [3:0]  cfgByteEnN,
  input  wire [31:0] cfgWriteData,
  output reg  [31:0] cfgReadData,
  output reg         cfgDone,
  input  wire        parityErrorEvent,
  input  wire        systemErrorEvent,
  input  wire        masterAbortEvent,
  input  wire        targetAbortRcvEvent,
  input  wire        targetAbortSentEvent,
  input  wire        dataParityEvent,
  input  wire        pmeEvent,
  output wire [15:0] commandBits,
  output wire [31:0] ioBase,
  output wire [31:0] memBase,
  output wire [31:0] romBase,
  output wire [7:0]  interruptLine,
  output wire [1:0]  powerState
);

  // reset release through two flip-flops
  reg        rstMeta;
  reg        rstSyncN;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // byte-lane merge of write data under a writable-bit mask
  function [31:0] laneMerge;
    input [31:0] oldValue;
    input [31:0] newValue;
    input [31:0] writeMask;
    input [3:0]  laneEnable;
    integer      i;
    begin
      laneMerge = oldValue;
      for (i = 0; i < 32; i = i + 1) begin
        if (laneEnable[i / 8] && writeMask[i]) begin
          laneMerge[i] = newValue[i];
        end
      end
    end
  endfunction

  reg  [15:0] command_reg;
  reg  [15:0] command_next;
  reg  [7:0]  status_reg;
  wire [7:0]  status_next;
  wire [7:0]  statusClear;
  reg  [31:0] cmdMerged;
  reg  [31:0] ioBase_reg;
  reg  [31:0] ioBase_next;
  reg  [31:0] memBase_reg;
  reg  [31:0] memBase_next;
  reg  [31:0] romBase_reg;
  reg  [31:0] romBase_next;
  reg  [31:0] intSel_reg;
  reg  [31:0] intSel_next;
  reg  [31:0] pmCtrl_reg;
  reg  [31:0] pmCtrl_next;
  reg  [31:0] readValue;

  wire        accessValid;
  wire        writeValid;
  wire [7:0]  byteOffset;
  wire [3:0]  laneEnable;
  wire [31:0] clearBits;
  wire [7:0]  statusEvents;
  wire [15:0] statusWord;

  assign accessValid = cfgRequest && cfgTypeZero && cfgSelect;
  assign writeValid  = accessValid && cfgWrite;
  assign byteOffset  = {cfgDwordAddr, 2'b00};
  assign laneEnable  = ~cfgByteEnN;
  assign clearBits   = cfgWriteData & {{8{laneEnable[3]}}, {8{laneEnable[2]}},
                                       {8{laneEnable[1]}}, {8{laneEnable[0]}}};

  // stored flags: bits 31..27 in [7:3], data parity in [0], unused [2:1]
  assign statusEvents = {parityErrorEvent, systemErrorEvent, masterAbortEvent,
                         targetAbortRcvEvent, targetAbortSentEvent, 2'b00,
                         dataParityEvent};

  assign statusWord = {status_reg[7:3], `SELTIM_MEDIUM, status_reg[0], 8'h00}
                      | `STAT_FIXED;

  // write-one clears, only on a served write to the command/status word
  assign statusClear = (writeValid && (byteOffset == `OFF_CMDSTAT)) ?
                       {clearBits[31:27], 2'b00, clearBits[24]} : 8'h00;

  // one flag per bit; an event in the clearing cycle wins
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : flagBit
      assign status_next[g] = statusEvents[g] | (status_reg[g] & ~statusClear[g]);
    end
  endgenerate

  // next-state for writable registers
  always @* begin
    cmdMerged    = 32'h00000000;
    command_next = command_reg;
    ioBase_next  = ioBase_reg;
    memBase_next = memBase_reg;
    romBase_next = romBase_reg;
    intSel_next  = intSel_reg;
    pmCtrl_next  = pmCtrl_reg;
    if (writeValid) begin
      case (byteOffset)
        `OFF_CMDSTAT: begin
          cmdMerged    = laneMerge({16'h0000, command_reg}, cfgWriteData,
                                   {16'h0000, `CMD_WRITE_MASK}, laneEnable);
          command_next = cmdMerged[15:0];
        end
        `OFF_IOBASE: begin
          ioBase_next = laneMerge(ioBase_reg, cfgWriteData, `IOBASE_MASK, laneEnable);
        end
        `OFF_MEMBASE: begin
          memBase_next = laneMerge(memBase_reg, cfgWriteData, `MEMBASE_MASK, laneEnable);
        end
        `OFF_ROMBASE: begin
          romBase_next = laneMerge(romBase_reg, cfgWriteData, `ROMBASE_MASK, laneEnable);
        end
        `OFF_INTSEL: begin
          intSel_next = laneMerge(intSel_reg, cfgWriteData, `INTSEL_MASK, laneEnable);
        end
        `OFF_PMCTRL: begin
          pmCtrl_next = laneMerge(pmCtrl_reg, cfgWriteData, `PMCTRL_MASK, laneEnable)
                        & ~(clearBits & `PMCTRL_W1C);
        end
        default: begin
          command_next = command_reg;
        end
      endcase
    end
    if (pmeEvent) begin
      pmCtrl_next[`PMCTRL_PME_BIT] = 1'b1;
    end
  end

  // read multiplexer
  always @* begin
    case (byteOffset)
      `OFF_IDENT:    readValue = {DEVICE_IDENTIFIER, VENDOR_IDENTIFIER};
      `OFF_CMDSTAT:  readValue = {statusWord, command_reg};
      `OFF_REVISION: readValue = REVISION_VALUE;
      `OFF_LATENCY:  readValue = LATENCY_VALUE;
      `OFF_IOBASE:   readValue = ioBase_reg;
      `OFF_MEMBASE:  readValue = memBase_reg;
      `OFF_SUBSYS:   readValue = SUBSYSTEM_VALUE;
      `OFF_ROMBASE:  readValue = romBase_reg;
      `OFF_CAPABILITY_LIST_POINTER:   readValue = {24'h000000, CAP_POINTER};
      `OFF_INTSEL:   readValue = intSel_reg;
      `OFF_POWER_CAPABILITIES:    readValue = POWER_CAPABILITIES_VALUE;
      `OFF_PMCTRL:   readValue = pmCtrl_reg;
      default:       readValue = 32'h00000000;
    endcase
  end

  // register state; only the hardware reset clears it
  always @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      command_reg <= `CMD_RESET;
      status_reg  <= 8'h00;
      ioBase_reg  <= `IOBASE_RESET;
      memBase_reg <= `MEMBASE_RESET;
      romBase_reg <= `ROMBASE_RESET;
      intSel_reg  <= `INTSEL_RESET;
      pmCtrl_reg  <= `PMCTRL_RESET;
    end else begin
      // softResetReq deliberately absent here
      command_reg <= command_next;
      status_reg  <= status_next;
      ioBase_reg  <= ioBase_next;
      memBase_reg <= memBase_next;
      romBase_reg <= romBase_next;
      intSel_reg  <= intSel_next;
      pmCtrl_reg  <= pmCtrl_next;
    end
  end

  // answer one cycle after a served request
  always @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cfgDone     <= 1'b0;
      cfgReadData <= 32'h00000000;
    end else begin
      cfgDone <= accessValid;
      if (accessValid && !cfgWrite) begin
        cfgReadData <= readValue;
      end
    end
  end

  assign commandBits   = command_reg;
  assign ioBase        = ioBase_reg;
  assign memBase       = memBase_reg;
  assign romBase       = romBase_reg;
  assign interruptLine = intSel_reg[7:0];
  assign powerState    = pmCtrl_reg[1:0];

endmodule

// ===== tb/cfg_space_props.sv
// checker for the configuration register space
`timescale 1ns/1ps
module cfg_space_props (
  input wire        clk,
  input wire        resetn,
  input wire        cfgRequest,
  input wire        cfgWrite,
  input wire        cfgTypeZero,
  input wire        cfgSelect,
  input wire [7:2]  cfgDwordAddr,
  input wire [3:0]  cfgByteEnN,
  input wire [31:0] cfgWriteData,
  input wire [31:0] cfgReadData,
  input wire        cfgDone,
  input wire [15:0] commandBits,
  input wire [31:0] ioBase
);
  wire srv = cfgRequest & cfgTypeZero & cfgSelect;
  wire rd  = srv & ~cfgWrite;
  wire wra = srv & cfgWrite & (cfgByteEnN == 4'h0);
  wire rsv = (cfgDwordAddr >= 6'h06 && cfgDwordAddr <= 6'h0A) || cfgDwordAddr == 6'h0E || cfgDwordAddr >= 6'h12;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  done_after_req_a: assert property (srv |=> cfgDone)
    else $error("no done after served access");
  no_stray_done_a: assert property (!srv |=> !cfgDone)
    else $error("done without served access");
  ident_fixed_a: assert property (rd && cfgDwordAddr == 6'h00 |=> cfgReadData == 32'h1234ABCD)
    else $error("identification value wrong");
  sel_timing_a: assert property (rd && cfgDwordAddr == 6'h01 |=> cfgReadData[26:25] == 2'h1)
    else $error("select timing field wrong");
  reserved_zero_a: assert property (rd && rsv |=> cfgReadData == 32'h00000000)
    else $error("reserved offset not zero");
  rdata_hold_a: assert property (!rd |=> $stable(cfgReadData))
    else $error("read data moved without read");
  iobase_wr_a: assert property (wra && cfgDwordAddr == 6'h04 |=> ioBase == {$past(cfgWriteData[31:8]), 8'h01})
    else $error("io base write wrong");
  cmd_wr_a: assert property (wra && cfgDwordAddr == 6'h01 |=> commandBits == ($past(cfgWriteData[15:0]) & 16'h0347))
    else $error("command write wrong");
  cover property (rd);
  cover property (wra);
  cover property (cfgRequest && !cfgSelect);
endmodule
bind pci_config_space_header cfg_space_props u_props (.clk, .resetn, .cfgRequest, .cfgWrite, .cfgTypeZero, .cfgSelect,
  .cfgDwordAddr, .cfgByteEnN, .cfgWriteData, .cfgReadData, .cfgDone, .commandBits, .ioBase);

// ===== tb/host_bridge.sv
// host bridge model issuing configuration cycles
`timescale 1ns/1ps
module host_bridge (
  input  wire        clk,
  input  wire        cfgDone,
  input  wire [31:0] cfgReadData,
  output logic       cfgRequest = 1'b0,
  output logic       cfgWrite = 1'b0,
  output logic       cfgTypeZero = 1'b0,
  output logic       cfgSelect = 1'b0,
  output logic [7:2] cfgDwordAddr = 6'h00,
  output logic [3:0] cfgByteEnN = 4'hF,
  output logic [31:0] cfgWriteData = 32'h00000000
);
  task automatic xfer(input logic w, t, s, input logic [7:2] a, input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q, output logic done);
    @(posedge clk);
    cfgRequest <= 1'b1;
    cfgWrite <= w;
    cfgTypeZero <= t;
    cfgSelect <= s;
    cfgDwordAddr <= a;
    cfgByteEnN <= be;
    cfgWriteData <= d;
    @(posedge clk);
    cfgRequest <= 1'b0;
    cfgByteEnN <= ~be;
    cfgWriteData <= ~d;
    #1;
    done = cfgDone;
    q = cfgReadData;
  endtask
endmodule

// ===== tb/tb.sv
// testbench for the configuration register space
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        softResetReq = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic        cfgRequest, cfgWrite, cfgTypeZero, cfgSelect, cfgDone, ok;
  logic [7:2]  cfgDwordAddr;
  logic [3:0]  cfgByteEnN;
  logic [15:0] commandBits;
  logic [31:0] cfgWriteData, cfgReadData, ioBase, q;
  int          bad_count = 0;
  int          checks_done = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  pci_config_space_header u_dut (.clk, .resetn, .softResetReq, .cfgRequest, .cfgWrite, .cfgTypeZero, .cfgSelect,
    .cfgDwordAddr, .cfgByteEnN, .cfgWriteData, .cfgReadData, .cfgDone, .parityErrorEvent(ev[5]),
    .systemErrorEvent(ev[4]), .masterAbortEvent(ev[3]), .targetAbortRcvEvent(ev[2]), .targetAbortSentEvent(ev[1]),
    .dataParityEvent(ev[0]), .pmeEvent(1'b0), .commandBits, .ioBase, .memBase(), .romBase(), .interruptLine(),
    .powerState());
  host_bridge u_host (.clk, .cfgDone, .cfgReadData, .cfgRequest, .cfgWrite, .cfgTypeZero, .cfgSelect,
    .cfgDwordAddr, .cfgByteEnN, .cfgWriteData);
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:2] a, input logic [3:0] be, input logic [31:0] d);
    u_host.xfer(1'b1, 1'b1, 1'b1, a, be, d, q, ok);
    ck({31'h0, ok}, 32'h1);
  endtask
  task automatic rdck(input logic [7:2] a, input logic [31:0] exp);
    u_host.xfer(1'b0, 1'b1, 1'b1, a, 4'h0, 32'h0, q, ok);
    ck({31'h0, ok}, 32'h1);
    ck(q, exp);
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
  endtask
  task automatic hw_reset;
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_readonly;
    logic [7:2]  ra[6] = '{6'h00, 6'h02, 6'h03, 6'h0B, 6'h0D, 6'h10};
    logic [31:0] rv[6] = '{32'h1234ABCD, 32'h02000000, 32'h0, 32'h0, 32'h00000040, 32'h00020001};
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], 4'h0, 32'hFFFFFFFF);
      rdck(ra[i], rv[i]);
    end
  endtask
  task automatic t_reserved;
    for (int a = 0; a < 64; a++) begin
      if ((a >= 6 && a <= 10) || a == 14 || a >= 18) begin
        wr(a[5:0], 4'h0, 32'hFFFFFFFF);
        rdck(a[5:0], 32'h0);
      end
    end
  endtask
  task automatic t_rw;
    wr(6'h04, 4'h0, 32'hAAAA5555);
    rdck(6'h04, 32'hAAAA5501);
    wr(6'h04, 4'h7, 32'h11223344);
    rdck(6'h04, 32'h11AA5501);
    u_host.xfer(1'b1, 1'b1, 1'b0, 6'h04, 4'h0, 32'h0, q, ok);
    ck({31'h0, ok}, 32'h0);
    u_host.xfer(1'b1, 1'b0, 1'b1, 6'h04, 4'h0, 32'h0, q, ok);
    ck({31'h0, ok}, 32'h0);
    rdck(6'h04, 32'h11AA5501);
    wr(6'h05, 4'h0, 32'hFFFFFFFF);
    rdck(6'h05, 32'hFFFFF000);
    wr(6'h0C, 4'h0, 32'hFFFFFFFF);
    rdck(6'h0C, 32'hFFFF0001);
    wr(6'h0F, 4'h0, 32'hFFFFFFFF);
    rdck(6'h0F, 32'h000000FF);
    wr(6'h11, 4'h0, 32'hFFFFFFFF);
    rdck(6'h11, 32'h00000103);
  endtask
  task automatic t_status;
    wr(6'h01, 4'h0, 32'h0000FFFF);
    ck({16'h0, commandBits}, 32'h0347);
    pulse(6'h21);
    rdck(6'h01, 32'h83900347);
    wr(6'h01, 4'h0, 32'h80000347);
    rdck(6'h01, 32'h03900347);
    pulse(6'h3F);
    rdck(6'h01, 32'hFB900347);
    wr(6'h01, 4'h0, 32'h00000347);
    rdck(6'h01, 32'hFB900347);
    wr(6'h01, 4'h0, 32'hFF000347);
    rdck(6'h01, 32'h02900347);
  endtask
  task automatic t_resets;
    @(posedge clk);
    softResetReq <= 1'b1;
    @(posedge clk);
    softResetReq <= 1'b0;
    rdck(6'h04, 32'h11AA5501);
    hw_reset();
    rdck(6'h04, 32'h00000001);
    rdck(6'h01, 32'h02900000);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    hw_reset();
    rdck(6'h00, 32'h1234ABCD);
    t_readonly();
    t_reserved();
    t_rw();
    t_status();
    t_resets();
    close_out();
  end
endmodule
